// ===== swd_pkg.sv
// Package of constants for the supervisor watchdog detector.
// Assumes a 25 MHz system clock; all counts are derived from that rate.
package swd_pkg;

  // ****************************************************************
  // Clock and timing
  // ****************************************************************
  localparam int unsigned CLK_HZ = 25000000;
  localparam int unsigned TIMEOUT_BASE_MS = 200;
  localparam int unsigned TIMEOUT_BASE_CYC = TIMEOUT_BASE_MS * (CLK_HZ / 1000);
  localparam int unsigned PULSE_W0_US = 10;
  localparam int unsigned PULSE_W1_US = 100;
  localparam int unsigned PULSE_W2_US = 1000;
  localparam int unsigned PULSE_W3_US = 10000;
  localparam int unsigned PULSE_W0_CYC = PULSE_W0_US * (CLK_HZ / 1000000);
  localparam int unsigned PULSE_W1_CYC = PULSE_W1_US * (CLK_HZ / 1000000);
  localparam int unsigned PULSE_W2_CYC = PULSE_W2_US * (CLK_HZ / 1000000);
  localparam int unsigned PULSE_W3_CYC = PULSE_W3_US * (CLK_HZ / 1000000);
  localparam int unsigned TIMEOUT_CNT_W = 29;
  localparam int unsigned PULSE_CNT_W = 18;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0] WDT_CFG_ADDR = 8'h9C;
  localparam logic [7:0] WDT_CFG_RESET = 8'h00;
  localparam logic [7:0] FAULT_STAT1_ADDR = 8'hF5;
  localparam logic [7:0] FAULT_STAT2_ADDR = 8'hF6;
  localparam int unsigned PERIOD_LSB = 0;
  localparam int unsigned PERIOD_W = 3;
  localparam int unsigned PWIDTH_LSB = 3;
  localparam int unsigned PWIDTH_W = 2;
  localparam int unsigned CFG_USED_W = 5;
  localparam int unsigned FAULT_BIT = 0;

  // ****************************************************************
  // Pulse generator states
  // ****************************************************************
  typedef enum logic [1:0] {
    SWD_P_IDLE = 2'b01,
    SWD_P_HIGH = 2'b10
  } swd_pstate_t;

endpackage

// ===== swd_pulse_if.sv
// Interface carrying a fire request and width code to the pulse maker.
// Assumes both ends run on the same system clock.
`timescale 1ns/10ps
interface swd_pulse_if;
  logic fire;
  logic [swd_pkg::PWIDTH_W-1:0] width_sel;
  logic pulse;
  modport ctrl (output fire, output width_sel, input pulse);
  modport gen (input fire, input width_sel, output pulse);
endinterface

// ===== swd_pulse_gen.sv
// Single positive pulse generator of selectable width.
// Assumes fire is a one-cycle pulse on the system clock.
`timescale 1ns/10ps
module swd_pulse_gen #(
  parameter int unsigned W2_CYC = swd_pkg::PULSE_W2_CYC,
  parameter int unsigned W3_CYC = swd_pkg::PULSE_W3_CYC
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // Request and pulse
  swd_pulse_if.gen pif
);

  swd_pkg::swd_pstate_t state_r;
  swd_pkg::swd_pstate_t state_nxt;
  logic [swd_pkg::PULSE_CNT_W-1:0] cnt_r;
  logic [swd_pkg::PULSE_CNT_W-1:0] cnt_nxt;
  logic [swd_pkg::PULSE_CNT_W-1:0] len;
  logic pulse_r;
  logic pulse_nxt;

  always_comb begin
    case (pif.width_sel)
      2'h0: len = swd_pkg::PULSE_CNT_W'(swd_pkg::PULSE_W0_CYC);
      2'h1: len = swd_pkg::PULSE_CNT_W'(swd_pkg::PULSE_W1_CYC);
      2'h2: len = swd_pkg::PULSE_CNT_W'(W2_CYC);
      default: len = swd_pkg::PULSE_CNT_W'(W3_CYC);
    endcase
  end

  // A fire during a running pulse is ignored; the pulse stays one clean
  // low-high-low shape rather than being stretched.
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    pulse_nxt = pulse_r;
    case (state_r)
      swd_pkg::SWD_P_IDLE: begin
        if (pif.fire) begin
          state_nxt = swd_pkg::SWD_P_HIGH;
          cnt_nxt = len - 1'b1;
          pulse_nxt = 1'b1;
        end
      end
      swd_pkg::SWD_P_HIGH: begin
        if (cnt_r == '0) begin
          state_nxt = swd_pkg::SWD_P_IDLE;
          pulse_nxt = 1'b0;
        end else begin
          cnt_nxt = cnt_r - 1'b1;
        end
      end
      default: begin
        state_nxt = swd_pkg::SWD_P_IDLE;
        pulse_nxt = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= swd_pkg::SWD_P_IDLE;
      cnt_r <= '0;
      pulse_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      pulse_r <= pulse_nxt;
    end
  end

  assign pif.pulse = pulse_r;

endmodule

// ===== swd_watchdog.sv
// Watchdog fault detector of a supply supervisor: top module.
// Assumes the serial bus engine presents decoded register strobes on
// clk_sys and that watchdog_input_pin is asynchronous to clk_sys.
// It assumes any inversion of the fault outputs is done in the macrocells.
`timescale 1ns/10ps
module swd_watchdog #(
  parameter int unsigned TIMEOUT_BASE_CYC = swd_pkg::TIMEOUT_BASE_CYC,
  parameter int unsigned PULSE_W2_CYC = swd_pkg::PULSE_W2_CYC,
  parameter int unsigned PULSE_W3_CYC = swd_pkg::PULSE_W3_CYC
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // Monitored pin
  input wire logic watchdog_input_pin,
  // Register access from the serial bus engine
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // Fault signals towards the logic macrocells
  output logic wdt_fault_latched,
  output logic wdt_fault_pulse
);

  // ****************************************************************
  // Pin synchroniser and edge detect
  // ****************************************************************
  logic [2:0] pin_sync_r;
  logic [2:0] pin_sync_nxt;
  logic activity;

  // A pin level held for less than a clock may be missed entirely; the
  // monitored processor must hold each level for a few clocks.
  always_comb begin
    pin_sync_nxt = {pin_sync_r[1:0], watchdog_input_pin};
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pin_sync_r <= 3'h0;
    end else begin
      pin_sync_r <= pin_sync_nxt;
    end
  end

  // Only the second and third stages are compared, never the first.
  assign activity = pin_sync_r[2] ^ pin_sync_r[1];

  // ****************************************************************
  // Configuration register
  // ****************************************************************
  logic [swd_pkg::CFG_USED_W-1:0] cfg_r;
  logic [swd_pkg::CFG_USED_W-1:0] cfg_nxt;
  logic cfg_wr;
  logic [swd_pkg::PERIOD_W-1:0] period_sel;
  logic [swd_pkg::PWIDTH_W-1:0] width_sel;

  assign cfg_wr = reg_wr && (reg_addr == swd_pkg::WDT_CFG_ADDR);
  assign period_sel = cfg_r[swd_pkg::PERIOD_LSB +: swd_pkg::PERIOD_W];
  assign width_sel = cfg_r[swd_pkg::PWIDTH_LSB +: swd_pkg::PWIDTH_W];

  // Bits 7..5 are not stored, so they always read back as zero.
  always_comb begin
    cfg_nxt = cfg_r;
    if (cfg_wr) begin
      cfg_nxt = reg_wdata[swd_pkg::CFG_USED_W-1:0];
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      cfg_r <= swd_pkg::WDT_CFG_RESET[swd_pkg::CFG_USED_W-1:0];
    end else begin
      cfg_r <= cfg_nxt;
    end
  end

  // ****************************************************************
  // Timeout counter
  // ****************************************************************
  logic [swd_pkg::TIMEOUT_CNT_W-1:0] tmo_cnt_r;
  logic [swd_pkg::TIMEOUT_CNT_W-1:0] tmo_cnt_nxt;
  logic [swd_pkg::TIMEOUT_CNT_W-1:0] tmo_limit;
  logic expire;

  // Each code doubles the base period, so a shift replaces a table.
  always_comb begin
    if (period_sel == '0) begin
      tmo_limit = '0;
    end else begin
      tmo_limit = swd_pkg::TIMEOUT_CNT_W'(TIMEOUT_BASE_CYC)
                  << (period_sel - 3'h1);
    end
  end

  assign expire = (period_sel != '0) && !activity
                  && (tmo_cnt_r == tmo_limit - 1'b1);

  // Any config write restarts the count, even one that keeps the period;
  // software may use such a write as a kick besides pin activity.
  always_comb begin
    tmo_cnt_nxt = tmo_cnt_r + 1'b1;
    if (period_sel == '0 || activity || cfg_wr || expire) begin
      tmo_cnt_nxt = '0;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      tmo_cnt_r <= '0;
    end else begin
      tmo_cnt_r <= tmo_cnt_nxt;
    end
  end

  // ****************************************************************
  // Latched fault and status read sequence
  // ****************************************************************
  logic fault_r;
  logic fault_nxt;
  logic armed_r;
  logic armed_nxt;
  logic rd_stat1;
  logic rd_stat2;

  // A second-register read without the first one disarms, so a stray
  // read can never clear the flag on its own.
  assign rd_stat1 = reg_rd && (reg_addr == swd_pkg::FAULT_STAT1_ADDR);
  assign rd_stat2 = reg_rd && (reg_addr == swd_pkg::FAULT_STAT2_ADDR);

  // A new expiry in the cycle of the clearing read keeps the flag set.
  always_comb begin
    fault_nxt = fault_r;
    armed_nxt = armed_r;
    if (rd_stat1) begin
      armed_nxt = 1'b1;
    end else if (rd_stat2) begin
      armed_nxt = 1'b0;
      if (armed_r) begin
        fault_nxt = 1'b0;
      end
    end
    if (expire) begin
      fault_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      fault_r <= 1'b0;
      armed_r <= 1'b0;
    end else begin
      fault_r <= fault_nxt;
      armed_r <= armed_nxt;
    end
  end

  // ****************************************************************
  // Read data
  // ****************************************************************
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;

  // Read data holds between reads, so a slow bus engine may fetch it late.
  always_comb begin
    rdata_nxt = rdata_r;
    if (reg_rd) begin
      rdata_nxt = 8'h00;
      if (reg_addr == swd_pkg::WDT_CFG_ADDR) begin
        rdata_nxt = {3'h0, cfg_r};
      end else if (rd_stat1 || rd_stat2) begin
        rdata_nxt[swd_pkg::FAULT_BIT] = fault_r;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign reg_rdata = rdata_r;

  // ****************************************************************
  // Reset pulse and outputs
  // ****************************************************************
  swd_pulse_if pif ();

  // The width code is taken when the pulse fires, so a later write cannot
  // reshape a pulse that is already running.
  assign pif.fire = expire;
  assign pif.width_sel = width_sel;

  swd_pulse_gen #(
    .W2_CYC(PULSE_W2_CYC),
    .W3_CYC(PULSE_W3_CYC)
  ) u_pulse (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .pif(pif)
  );

  // Inversion is left to the macrocells, so both leave active high.
  assign wdt_fault_latched = fault_r;
  assign wdt_fault_pulse = pif.pulse;

endmodule

// ===== swd_watchdog_assertions.sv
// Concurrent checks on the ports of the watchdog detector top module.
// Assumes it is bound to swd_watchdog and sees only that module's ports.
`timescale 1ns/10ps
module swd_watchdog_chk #(
  parameter int unsigned TIMEOUT_BASE_CYC = swd_pkg::TIMEOUT_BASE_CYC,
  parameter int unsigned PULSE_W2_CYC = swd_pkg::PULSE_W2_CYC,
  parameter int unsigned PULSE_W3_CYC = swd_pkg::PULSE_W3_CYC
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // Watched ports
  input wire logic watchdog_input_pin,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic wdt_fault_latched,
  input wire logic wdt_fault_pulse
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  // ****************************************************************
  // Shadow state
  // ****************************************************************
  logic [4:0] cfg_r, cfg_nxt;
  logic [1:0] ws_r, ws_nxt;
  logic arm_r, arm_nxt, pin_r;
  int unsigned idle_r, idle_nxt, pc_r, pc_nxt;
  logic cw;

  function automatic int unsigned lim(input logic [2:0] s);
    return (s == 3'h0) ? 32'hFFFF_FFFF : TIMEOUT_BASE_CYC << (s - 3'h1);
  endfunction
  function automatic int unsigned wid(input logic [1:0] w);
    return (w == 2'h0) ? swd_pkg::PULSE_W0_CYC : (w == 2'h1) ?
      swd_pkg::PULSE_W1_CYC : (w == 2'h2) ? PULSE_W2_CYC : PULSE_W3_CYC;
  endfunction

  // Idle time is counted from the pin change itself, so it leads the
  // design's synchronised view; the bounds below allow for that lag.
  always_comb begin
    cw = reg_wr && reg_addr == 8'h9C;
    cfg_nxt = cw ? reg_wdata[4:0] : cfg_r;
    ws_nxt = wdt_fault_pulse ? ws_r : cfg_r[4:3];
    arm_nxt = (reg_rd && reg_addr == 8'hF5) ? 1'b1 :
      (reg_rd && reg_addr == 8'hF6) ? 1'b0 : arm_r;
    idle_nxt = (cw || watchdog_input_pin != pin_r) ? 32'h0 :
      idle_r + (idle_r != 32'hFFFF_FFFF);
    pc_nxt = wdt_fault_pulse ? pc_r + 32'h1 : 32'h0;
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      cfg_r <= 5'h00;
      ws_r <= 2'h0;
      arm_r <= 1'b0;
      pin_r <= 1'b0;
      idle_r <= 32'h0;
      pc_r <= 32'h0;
    end else begin
      cfg_r <= cfg_nxt;
      ws_r <= ws_nxt;
      arm_r <= arm_nxt;
      pin_r <= watchdog_input_pin;
      idle_r <= idle_nxt;
      pc_r <= pc_nxt;
    end
  end

  pulse_width_a: assert property (
    $fell(wdt_fault_pulse) |-> pc_r == wid(ws_r))
    else $error("reset pulse width wrong");
  pulse_latch_a: assert property (
    $rose(wdt_fault_pulse) |-> wdt_fault_latched)
    else $error("pulse without latched fault");
  no_early_a: assert property (
    $rose(wdt_fault_latched) |-> idle_r >= lim(cfg_r[2:0]))
    else $error("fault before timeout");
  fault_due_a: assert property (
    (cfg_r[2:0] != 3'h0 && idle_r == lim(cfg_r[2:0]) + 32'h6)
    |-> wdt_fault_latched) else $error("fault missing after timeout");
  clear_pair_a: assert property (
    $fell(wdt_fault_latched) |-> $past(reg_rd && reg_addr == 8'hF6 && arm_r))
    else $error("latched fault cleared without read pair");
  cfg_read_a: assert property (
    (reg_rd && reg_addr == 8'h9C) |=> reg_rdata == {3'h0, $past(cfg_r)})
    else $error("config read back wrong");
  unmapped_rd_a: assert property (
    (reg_rd && !(reg_addr inside {8'h9C, 8'hF5, 8'hF6})) |=>
    reg_rdata == 8'h00) else $error("unmapped read not zero");
  status_rd_a: assert property (
    (reg_rd && reg_addr == 8'hF5) |=>
    reg_rdata[0] == $past(wdt_fault_latched)) else $error("status bit wrong");
endmodule

bind swd_watchdog swd_watchdog_chk #(
  .TIMEOUT_BASE_CYC(TIMEOUT_BASE_CYC),
  .PULSE_W2_CYC(PULSE_W2_CYC),
  .PULSE_W3_CYC(PULSE_W3_CYC)
) u_chk (.clk_sys(clk_sys), .arst_n(arst_n),
  .watchdog_input_pin(watchdog_input_pin), .reg_addr(reg_addr),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata), .wdt_fault_latched(wdt_fault_latched),
  .wdt_fault_pulse(wdt_fault_pulse));

// ===== swd_proc_model.sv
// Monitored processor: toggles its heartbeat pin while running.
// Assumes the bench changes the gap between toggles as it likes.
`timescale 1ns/10ps
module swd_proc_model (
  // Clock
  input wire logic clk_sys,
  // Control from the bench
  input wire logic run,
  input wire logic [3:0] gap,
  // Heartbeat pin
  output logic watchdog_input_pin
);
  int cnt = 0;
  initial watchdog_input_pin = 1'b0;
  // A stopped processor leaves the pin stuck, which is the fault case.
  always @(negedge clk_sys) begin
    if (run) begin
      cnt = cnt + 1;
      if (cnt >= gap) begin
        watchdog_input_pin = ~watchdog_input_pin;
        cnt = 0;
      end
    end
  end
endmodule

// ===== swd_tb.sv
// Self-checking bench for the watchdog detector.
// Assumes short timing parameters so every period fits a brief run.
`timescale 1ns/10ps
module tb;
  // ****************************************************************
  // Signals and bookkeeping
  // ****************************************************************
  logic clk_sys, arst_n, reg_wr, reg_rd, rd_d, run;
  logic [7:0] reg_addr, reg_wdata;
  logic [3:0] gap;
  wire logic [7:0] reg_rdata;
  wire logic pin, lat, pls;
  int num_errors = 0, tests_run = 0, seed, n, pw = 0, w, i;
  logic [7:0] rdq[$];
  int wq[$];

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  swd_watchdog #(.TIMEOUT_BASE_CYC(32'h14), .PULSE_W2_CYC(32'h1E),
    .PULSE_W3_CYC(32'h28)) dut (.clk_sys(clk_sys), .arst_n(arst_n),
    .watchdog_input_pin(pin), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .wdt_fault_latched(lat), .wdt_fault_pulse(pls));
  swd_proc_model u_proc (.clk_sys(clk_sys), .run(run), .gap(gap),
    .watchdog_input_pin(pin));

  function automatic int lim(input int s);
    return 32'h14 << (s - 1);
  endfunction
  function automatic int wid(input int k);
    return (k == 0) ? swd_pkg::PULSE_W0_CYC : (k == 1) ?
      swd_pkg::PULSE_W1_CYC : (k == 2) ? 32'h1E : 32'h28;
  endfunction

  task automatic tally_and_finish;
    if (num_errors == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk_byte(input string nm, input logic [7:0] e, g);
    tests_run++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_num(input string nm, input int e, g);
    tests_run++;
    if (g != e) begin
      num_errors++;
      $display("CHECK FAILED %s expected %0d seen %0d", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    @(negedge clk_sys);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk_sys);
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, e);
    @(negedge clk_sys);
    reg_addr = a;
    reg_rd = 1'b1;
    rdq.push_back(e);
    @(negedge clk_sys);
    reg_rd = 1'b0;
  endtask
  task automatic wait_sig(input bit sel, input logic v, input int bound);
    n = 0;
    while (((sel ? pls : lat) !== v) && n < bound) begin
      @(negedge clk_sys);
      n++;
    end
    if (n >= bound) begin
      num_errors++;
      $display("CHECK FAILED wait expected %b seen timeout", v);
      tally_and_finish;
    end
  endtask
  task automatic clear_fault;
    rd(8'hF6, 8'h01);
    chk_byte("latched", 8'h01, {7'h0, lat});
    rd(8'hF5, 8'h01);
    rd(8'h9D, 8'h00);
    rd(8'hF6, 8'h01);
    chk_byte("latched", 8'h00, {7'h0, lat});
    rd(8'hF5, 8'h00);
    rd(8'hF6, 8'h00);
  endtask

  // Reads are answered one cycle late; pulses are measured in cycles.
  always @(posedge clk_sys) begin
    if (rd_d) chk_byte("read data", rdq.pop_front(), reg_rdata);
    rd_d <= reg_rd;
    if (pls === 1'b1) pw++;
    else if (pw != 0) begin
      chk_num("pulse width", wq.pop_front(), pw);
      pw = 0;
    end
  end

  initial begin
    seed = 32'h2bf3784c;
    {arst_n, reg_wr, reg_rd, run, reg_addr, reg_wdata} = '0;
    gap = 4'h8;
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    arst_n = 1'b1;
    rd(8'h9C, 8'h00);
    wr(8'h9C, 8'hFF);
    rd(8'h9C, 8'h1F);
    wr(8'h9C, 8'($random(seed)) & 8'hF8);
    repeat (100) @(negedge clk_sys);
    chk_byte("disabled", 8'h00, {7'h0, lat});
    for (i = 1; i < 8; i++) begin
      w = i % 4;
      wq.push_back(wid(w));
      wr(8'h9C, {3'($random(seed)), 2'(w), 3'(i)});
      wait_sig(1'b0, 1'b1, lim(i) + 10);
      chk_num("delay", 1, int'(n >= lim(i) - 1 && n <= lim(i) + 3));
      wr(8'h9C, {3'h0, 2'(w), 3'h0});
      wait_sig(1'b1, 1'b0, wid(w) + 10);
      clear_fault;
    end
    wr(8'h9C, 8'h01);
    run = 1'b1;
    for (i = 0; i < 30; i++) begin
      gap = 4'h8 + 4'(($random(seed) & 32'h7) % 7);
      repeat (10) @(negedge clk_sys);
    end
    chk_byte("active", 8'h00, {7'h0, lat});
    run = 1'b0;
    wq.push_back(wid(0));
    wait_sig(1'b0, 1'b1, 40);
    // Stay idle a while so the checker's late-fault check is reached.
    repeat (10) @(negedge clk_sys);
    chk_byte("held", 8'h01, {7'h0, lat});
    wr(8'h9C, 8'h00);
    wait_sig(1'b1, 1'b0, 270);
    clear_fault;
    repeat (2) @(negedge clk_sys);
    chk_num("pending notes", 0, rdq.size() + wq.size());
    tally_and_finish;
  end
endmodule
